// *** dv/host_cpu_model.sv ***
// Behavioural host controller driving the scheduler's backplane pins.
// Assumes the bench calls its tasks; pins change on falling edges.
`timescale 1ns/10ps
module host_cpu_model (
	input  wire logic ref_clk_in,
	output logic      host_reset_out  = 1'h0,
	output logic      sync_target_out = 1'h0,
	output logic      sync_cycle_out  = 1'h0,
	output logic      prog_done_out   = 1'h0
);
	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	// Pins start low; only the tasks below move them afterwards

	// Three cycles high and three low, so every edge is seen apart
	task automatic strobe(ref logic pin);
		@(negedge ref_clk_in) pin = 1'h1;
		repeat (3) @(negedge ref_clk_in);
		pin = 1'h0;
		repeat (3) @(negedge ref_clk_in);
	endtask

	task automatic set_target(input logic v);
		@(negedge ref_clk_in) sync_target_out = v;
	endtask

	task automatic host_reset();
		strobe(host_reset_out);
	endtask

	task automatic sync_cycle();
		strobe(sync_cycle_out);
	endtask

	task automatic prog_done();
		strobe(prog_done_out);
	endtask
endmodule

// *** dv/io_refresh_mode_scheduler_monitor.sv ***
// Checker of mode and refresh strobe timing at the scheduler's ports.
// Assumes one clock and synchronous reset; bound into the scheduler module.
`timescale 1ns/10ps
module sched_monitor (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic sync_cycle_in,
	input wire logic sync_prog_done_in,
	input wire logic sync_mode_out,
	input wire logic logic_run_out,
	input wire logic sync_align_out,
	input wire logic x_low_refresh_out,
	input wire logic x_high_refresh_out,
	input wire logic y_low_take_out,
	input wire logic y_high_take_out,
	input wire logic fast_ctrl_update_out,
	input wire logic fast_mon_refresh_out,
	input wire logic slow_area_refresh_out,
	input wire logic cfg_load_req_out,
	input wire logic cfg_loaded_out,
	input wire logic wdt_error_out
);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	chk_normal_fast_group: assert property (
		!sync_mode_out && x_low_refresh_out |-> x_high_refresh_out &&
		y_low_take_out && y_high_take_out && fast_ctrl_update_out &&
		fast_mon_refresh_out) else $error("fast group incomplete");
	chk_low_flag_gap: assert property (
		x_low_refresh_out |=> (!x_low_refresh_out) [*8])
		else $error("low flag refresh too close");
	chk_sync_low_slow: assert property (
		sync_mode_out && x_low_refresh_out |-> slow_area_refresh_out)
		else $error("sync low flags off the slow tick");
	chk_slow_area_set: assert property (
		slow_area_refresh_out |-> x_low_refresh_out && y_low_take_out &&
		fast_mon_refresh_out) else $error("slow tick group incomplete");
	chk_cycle_start_high: assert property (
		$rose(sync_cycle_in) && sync_mode_out |-> ##[2:5]
		(x_high_refresh_out && sync_align_out))
		else $error("cycle start not followed by refresh");
	chk_sync_high_cause: assert property (
		sync_mode_out && x_high_refresh_out |-> sync_align_out)
		else $error("upper flags refreshed off cycle start");
	chk_prog_done_take: assert property (
		$rose(sync_prog_done_in) && sync_mode_out |-> ##[2:5]
		(y_high_take_out && fast_ctrl_update_out))
		else $error("program end not followed by take");
	chk_run_normal_only: assert property (
		logic_run_out |-> !sync_mode_out && cfg_loaded_out &&
		!wdt_error_out) else $error("logic runs out of normal mode");
	chk_wdt_sticky: assert property (
		wdt_error_out |=> wdt_error_out)
		else $error("watchdog error cleared");
	chk_load_exclusive: assert property (
		cfg_load_req_out |-> !cfg_loaded_out)
		else $error("load requested while loaded");

	// Main scenarios reached
	cov_sync_align: cover property (sync_align_out);
	cov_wdt_trip: cover property ($rose(wdt_error_out));
	cov_normal_slow: cover property (slow_area_refresh_out && !sync_mode_out);
endmodule

bind io_refresh_mode_scheduler sched_monitor mon (.*);

// *** dv/tb_top.sv ***
// Self-checking bench for the refresh scheduler with short timebase.
// Assumes the host model drives pins; bench drives loader and heartbeat.
`timescale 1ns/10ps
module tb_top;
	import refresh_sched_pkg::*;
	localparam int F = 20;
	localparam int R = 3;
	logic ref_clk_in, sys_rst_in, hb_en, heartbeat_in, load_done, clk_en;
	wire  hrst, tgt, cyc, done, mode, run, align, xl, xh, yl, yh;
	wire  fc, fm, sa, lreq, loaded, wdt;
	wire  [4:0] pv = {wdt, xl, yh, xh, align};
	int   bad_count, compares, hb_cnt, n_xl, n_xh, n_sa;

	// ****************************************************************
	// Instances, clock, heartbeat
	// ****************************************************************
	host_cpu_model host (.ref_clk_in(ref_clk_in), .host_reset_out(hrst),
		.sync_target_out(tgt), .sync_cycle_out(cyc), .prog_done_out(done));
	io_refresh_mode_scheduler #(.FAST_CYCLES(F), .SLOW_RATIO(R),
		.WDT_TICKS(3)) dut (.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .host_reset_in(hrst),
		.sync_target_in(tgt), .sync_cycle_in(cyc),
		.sync_prog_done_in(done), .cfg_load_done_in(load_done),
		.heartbeat_in(heartbeat_in), .sync_mode_out(mode),
		.logic_run_out(run), .sync_align_out(align),
		.x_low_refresh_out(xl), .x_high_refresh_out(xh),
		.y_low_take_out(yl), .y_high_take_out(yh),
		.fast_ctrl_update_out(fc), .fast_mon_refresh_out(fm),
		.slow_area_refresh_out(sa), .cfg_load_req_out(lreq),
		.cfg_loaded_out(loaded), .wdt_error_out(wdt));

	initial begin
		ref_clk_in = 1'h0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end

	// Heartbeat every 8 cycles while enabled
	always @(negedge ref_clk_in) begin
		hb_cnt <= hb_cnt + 1;
		heartbeat_in <= hb_en && (hb_cnt % 8 == 0);
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic do_reset(input logic t);
		host.set_target(t);
		hb_en = 1'h1;
		load_done = 1'h0;
		sys_rst_in = 1'h1;
		repeat (5) @(negedge ref_clk_in);
		sys_rst_in = 1'h0;
		repeat (2) @(negedge ref_clk_in);
		check(8'({lreq, loaded}), 8'h02);
		load_done = 1'h1;
	endtask

	task automatic watch(input int n);
		n_xl = 0; n_xh = 0; n_sa = 0;
		repeat (n) begin
			n_xl += (xl === 1'h1);
			n_xh += (xh === 1'h1);
			n_sa += (sa === 1'h1);
			@(negedge ref_clk_in);
		end
	endtask

	task automatic wait_bit(input int idx);
		int k;
		for (k = 0; k < 400 && pv[idx] !== 1'h1; k++) @(negedge ref_clk_in);
		if (k == 400) begin
			bad_count++;
			wrap_up();
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_normal();
		do_reset(1'h0);
		wait_bit(3);
		check(8'(mode), 8'h00);
		check(8'({xh, yl, yh, fc, fm}), 8'h1F);
		check(8'(run), 8'h01);
		check(8'(loaded), 8'h01);
		@(negedge ref_clk_in);
		watch(F * R * 2);
		check(8'(n_xl), 8'h06);
		check(8'(n_sa), 8'h02);
		// Enable low freezes the timebase, so no refresh for two ticks
		clk_en = 1'h0;
		watch(F * 2);
		check(8'(n_xl), 8'h00);
		clk_en = 1'h1;
		$display("test_normal done");
	endtask

	task automatic test_wdt();
		hb_en = 1'h0;
		wait_bit(4);
		check(8'(run), 8'h00);
		hb_en = 1'h1;
		repeat (30) @(negedge ref_clk_in);
		check(8'(wdt), 8'h01);
		$display("test_wdt done");
	endtask

	task automatic test_sync();
		do_reset(1'h1);
		wait_bit(3);
		check(8'(mode), 8'h01);
		check(8'(run), 8'h00);
		check(8'({sa, yl, fm}), 8'h07);
		@(negedge ref_clk_in);
		watch(F * R * 2);
		check(8'(n_xl), 8'h02);
		check(8'(n_xh), 8'h00);
		// Pulses are judged in the cycle they stand, not after the strobe
		fork
			host.sync_cycle();
			begin
				wait_bit(1);
				check(8'({xh, yh}), 8'h02);
				check(8'({align, yh}), 8'h02);
			end
		join
		fork
			host.prog_done();
			begin
				wait_bit(2);
				check(8'({fc, xh}), 8'h02);
				check(8'(yl), 8'h00);
			end
		join
		host.set_target(1'h0);
		repeat (10) @(negedge ref_clk_in);
		check(8'(mode), 8'h01);
		host.host_reset();
		repeat (12) @(negedge ref_clk_in);
		check(8'(mode), 8'h00);
		$display("test_sync done");
	endtask

	initial begin
		sys_rst_in = 1'h1;
		load_done = 1'h0;
		hb_en = 1'h0;
		clk_en = 1'h1;
		bad_count = 0;
		compares = 0;
		test_normal();
		test_wdt();
		test_sync();
		wrap_up();
	end
endmodule

// *** verilog/io_refresh_mode_scheduler.sv ***
// Mode selection and refresh scheduling for the high-speed I/O module.
// Assumes backplane pins arrive asynchronously and the hardware logic,
// the non-volatile loader and the internal heartbeat share ref_clk_in.
`timescale 1ns/10ps

// Notes on behaviour
// - Mode latched only at power-on or host reset, sync if host targets it.
// - Untargeted module, the default, runs in normal mode.
// - Normal mode runs the user hardware logic.
// - Sync mode aligns function timing to the inter-module cycle start.
// - Low output flags refresh every 1 ms in sync, 100 us in normal.
// - Sync mode refreshes upper output flags at each sync cycle start.
// - Sync mode takes low input flags per 1 ms, upper ones at program end.
// - Fast-area control updates at program end in sync, 100 us in normal.
// - Sync mode refreshes fast-area monitor data every 1 ms.
// - Slow shared area control and monitor refresh every 1 ms always.
// - Stored logic loads from non-volatile memory at power-on.
// - Watchdog supervises internal processing and flags an error.
module io_refresh_mode_scheduler
	import refresh_sched_pkg::*;
#(
	parameter int FAST_CYCLES = FAST_TICK_CYCLES,
	parameter int SLOW_RATIO  = FAST_PER_SLOW,
	parameter int WDT_TICKS   = WDT_FAST_TICKS
) (
	input  wire logic ref_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic clk_en_in,
	input  wire logic host_reset_in,
	input  wire logic sync_target_in,
	input  wire logic sync_cycle_in,
	input  wire logic sync_prog_done_in,
	input  wire logic cfg_load_done_in,
	input  wire logic heartbeat_in,
	output logic      sync_mode_out,
	output logic      logic_run_out,
	output logic      sync_align_out,
	output logic      x_low_refresh_out,
	output logic      x_high_refresh_out,
	output logic      y_low_take_out,
	output logic      y_high_take_out,
	output logic      fast_ctrl_update_out,
	output logic      fast_mon_refresh_out,
	output logic      slow_area_refresh_out,
	output logic      cfg_load_req_out,
	output logic      cfg_loaded_out,
	output logic      wdt_error_out
);
	localparam int WW = $clog2(WDT_TICKS + 1);

	refresh_tick_if tick_bus ();

	// Synchronisers: stage 1 read only by stage 2
	logic [3:0] pin_meta_reg;
	logic [3:0] pin_sync_reg;
	logic [3:0] pin_prev_reg;

	mode_e       mode_reg;
	logic [1:0]  capture_cnt_reg;
	load_state_e load_reg;
	load_state_e load_next;
	logic [WW-1:0] wdt_cnt_reg;
	logic        wdt_err_reg;

	logic x_low_reg;
	logic x_high_reg;
	logic y_low_reg;
	logic y_high_reg;
	logic fctrl_reg;
	logic fmon_reg;
	logic slow_reg;
	logic align_reg;

	wire host_rst_edge;
	wire cycle_edge;
	wire prog_done_edge;
	wire in_sync;
	wire fast;
	wire slow;
	wire capture_now;
	wire x_low_next;
	wire x_high_next;
	wire y_low_next;
	wire y_high_next;
	wire fctrl_next;
	wire fmon_next;
	wire slow_next;
	wire wdt_expire;

	// ****************************************************************
	// Timebase
	// ****************************************************************
	refresh_tick_gen #(
		.FAST_CYCLES (FAST_CYCLES),
		.SLOW_RATIO  (SLOW_RATIO)
	) u_ticks (
		.ref_clk_in (ref_clk_in),
		.sys_rst_in (sys_rst_in),
		.clk_en_in  (clk_en_in),
		.ticks      (tick_bus.source)
	);

	assign fast = tick_bus.fast_tick;
	assign slow = tick_bus.slow_tick;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Bits: 0 host reset, 1 target, 2 sync cycle, 3 program done
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pin_meta_reg <= 4'h0;
			pin_sync_reg <= 4'h0;
			pin_prev_reg <= 4'h0;
		end else if (clk_en_in) begin
			pin_meta_reg <= {sync_prog_done_in, sync_cycle_in,
				sync_target_in, host_reset_in};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	// Edge decodes on synchronised levels
	assign host_rst_edge  = rise(pin_sync_reg[0], pin_prev_reg[0]);
	assign cycle_edge     = rise(pin_sync_reg[2], pin_prev_reg[2]);
	assign prog_done_edge = rise(pin_sync_reg[3], pin_prev_reg[3]);

	// ****************************************************************
	// Mode selection
	// ****************************************************************
	// Capture once the synchroniser holds a real sample
	assign capture_now = (capture_cnt_reg == 2'h1);

	// Mode latch, reloaded only at power-on or host reset
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			capture_cnt_reg <= MODE_CAPTURE_DELAY;
			mode_reg        <= MODE_NORMAL;
		end else if (clk_en_in) begin
			if (host_rst_edge) begin
				capture_cnt_reg <= MODE_CAPTURE_DELAY;
			end else if (capture_cnt_reg != 2'h0) begin
				capture_cnt_reg <= capture_cnt_reg - 2'h1;
			end
			if (capture_now) begin
				mode_reg <= pin_sync_reg[1] ? MODE_SYNC : MODE_NORMAL;
			end
		end
	end

	assign in_sync = (mode_reg == MODE_SYNC);

	// ****************************************************************
	// Refresh schedule
	// ****************************************************************
	// Strobe selection per mode
	assign x_low_next  = in_sync ? slow : fast;
	assign x_high_next = in_sync ? cycle_edge : fast;
	assign y_low_next  = in_sync ? slow : fast;
	assign y_high_next = in_sync ? prog_done_edge : fast;
	assign fctrl_next  = in_sync ? prog_done_edge : fast;
	assign fmon_next   = in_sync ? slow : fast;
	assign slow_next   = slow;

	// Registered strobes; all but align_reg quiet until mode is settled
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			x_low_reg  <= 1'b0;
			x_high_reg <= 1'b0;
			y_low_reg  <= 1'b0;
			y_high_reg <= 1'b0;
			fctrl_reg  <= 1'b0;
			fmon_reg   <= 1'b0;
			slow_reg   <= 1'b0;
			align_reg  <= 1'b0;
		end else if (clk_en_in) begin
			x_low_reg  <= x_low_next & (capture_cnt_reg == 2'h0);
			x_high_reg <= x_high_next & (capture_cnt_reg == 2'h0);
			y_low_reg  <= y_low_next & (capture_cnt_reg == 2'h0);
			y_high_reg <= y_high_next & (capture_cnt_reg == 2'h0);
			fctrl_reg  <= fctrl_next & (capture_cnt_reg == 2'h0);
			fmon_reg   <= fmon_next & (capture_cnt_reg == 2'h0);
			slow_reg   <= slow_next & (capture_cnt_reg == 2'h0);
			align_reg  <= in_sync & cycle_edge;
		end
	end

	// ****************************************************************
	// Configuration load
	// ****************************************************************
	// Next-state decode for the load sequencer
	always_comb begin
		load_next = load_reg;
		unique case (load_reg)
			LOAD_START: load_next = LOAD_WAIT;
			LOAD_WAIT:  if (cfg_load_done_in) begin
				load_next = LOAD_DONE;
			end
			LOAD_DONE:  load_next = LOAD_DONE;
			default:    load_next = LOAD_START;
		endcase
	end

	// Automatic load after power-on
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			load_reg <= LOAD_START;
		end else if (clk_en_in) begin
			load_reg <= load_next;
		end
	end

	// ****************************************************************
	// Watchdog
	// ****************************************************************
	assign wdt_expire = (wdt_cnt_reg == WW'(WDT_TICKS));

	// Heartbeat restarts the count; expiry latches the error
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			wdt_cnt_reg <= '0;
			wdt_err_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (heartbeat_in) begin
				wdt_cnt_reg <= '0;
			end else if (fast && !wdt_expire) begin
				wdt_cnt_reg <= wdt_cnt_reg + WW'(1);
			end
			if (wdt_expire) begin
				wdt_err_reg <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign sync_mode_out         = in_sync;
	assign logic_run_out         = ~in_sync & (load_reg == LOAD_DONE)
		& ~wdt_err_reg;
	assign sync_align_out        = align_reg;
	assign x_low_refresh_out     = x_low_reg;
	assign x_high_refresh_out    = x_high_reg;
	assign y_low_take_out        = y_low_reg;
	assign y_high_take_out       = y_high_reg;
	assign fast_ctrl_update_out  = fctrl_reg;
	assign fast_mon_refresh_out  = fmon_reg;
	assign slow_area_refresh_out = slow_reg;
	assign cfg_load_req_out      = (load_reg == LOAD_WAIT);
	assign cfg_loaded_out        = (load_reg == LOAD_DONE);
	assign wdt_error_out         = wdt_err_reg;
endmodule

// *** verilog/refresh_sched_pkg.sv ***
// Package of constants shared by the refresh scheduler and its tick source.
// Assumes a single 250 MHz clock domain and no software-visible registers.
package refresh_sched_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS    = 4000;    // 250 MHz clock
	localparam int T_FAST_TICK_US   = 100;     // Normal-mode refresh tick
	localparam int T_SLOW_TICK_MS   = 1;       // Slow refresh tick
	localparam int FAST_TICK_CYCLES =
		(T_FAST_TICK_US * 1000000) / CLK_PERIOD_PS;
	localparam int FAST_PER_SLOW    =
		(T_SLOW_TICK_MS * 1000) / T_FAST_TICK_US;
	localparam int WDT_FAST_TICKS   = 10;      // Watchdog limit in fast ticks

	// ****************************************************************
	// Reset and start-up values
	// ****************************************************************
	localparam logic [1:0] MODE_CAPTURE_DELAY = 2'h3; // Fill synchroniser
	localparam logic       MODE_SYNC_RESET    = 1'h0; // Normal by default

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic {
		MODE_NORMAL,
		MODE_SYNC
	} mode_e;

	typedef enum logic [1:0] {
		LOAD_START,
		LOAD_WAIT,
		LOAD_DONE
	} load_state_e;

	// Rising edge of a sampled level
	function automatic logic rise(input logic cur, input logic prev);
		rise = cur & ~prev;
	endfunction

endpackage

// *** verilog/refresh_tick_gen.sv ***
// Free-running timebase making the 100 us and 1 ms refresh pulses.
// Assumes synchronous active-high reset and a common clock enable.
`timescale 1ns/10ps
module refresh_tick_gen
	import refresh_sched_pkg::*;
#(
	parameter int FAST_CYCLES = FAST_TICK_CYCLES,
	parameter int SLOW_RATIO  = FAST_PER_SLOW
) (
	input  wire logic          ref_clk_in,
	input  wire logic          sys_rst_in,
	input  wire logic          clk_en_in,
	refresh_tick_if.source     ticks
);
	localparam int CW = $clog2(FAST_CYCLES);
	localparam int SW = $clog2(SLOW_RATIO + 1);

	logic [CW-1:0] cyc_reg;
	logic [SW-1:0] div_reg;
	logic          fast_tick_reg;
	logic          slow_tick_reg;
	wire           cyc_wrap;
	wire           div_wrap;

	// ****************************************************************
	// Counters
	// ****************************************************************
	// Wrap decodes
	assign cyc_wrap = (cyc_reg == CW'(FAST_CYCLES - 1));
	assign div_wrap = (div_reg == SW'(SLOW_RATIO - 1));

	// Cycle counter and tick divider
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cyc_reg       <= '0;
			div_reg       <= '0;
			fast_tick_reg <= 1'b0;
			slow_tick_reg <= 1'b0;
		end else if (clk_en_in) begin
			cyc_reg       <= cyc_wrap ? '0 : cyc_reg + CW'(1);
			fast_tick_reg <= cyc_wrap;
			slow_tick_reg <= cyc_wrap & div_wrap;
			if (cyc_wrap) begin
				div_reg <= div_wrap ? '0 : div_reg + SW'(1);
			end
		end
	end

	assign ticks.fast_tick = fast_tick_reg;
	assign ticks.slow_tick = slow_tick_reg;
endmodule

// *** verilog/refresh_tick_if.sv ***
// Interface carrying the periodic refresh ticks between tick source and
// scheduler. Both ends share ref_clk_in.
`timescale 1ns/10ps
interface refresh_tick_if;
	logic fast_tick;   // One-cycle pulse every 100 us
	logic slow_tick;   // One-cycle pulse every 1 ms, coincides with fast

	modport source (output fast_tick, output slow_tick);
	modport sink   (input  fast_tick, input  slow_tick);
endinterface
